// ==== design/tdr_drift_engine.sv ====
// Reference tracking, detect state, anti-touch recalibration and reburst control
// What this block does
// (RULE_01) Extra confirmation measurements are requested during calibration, detect confirmation and recalibration.
// (RULE_02) The reburst policy picks none, only unresolved channels, or all active channels for extra measurements.
// (RULE_03) A signal above its reference raises the reference one count per upward period of rate times 200 ms.
// (RULE_04) With drift gain on, each upward step is the channel gain instead of one count.
// (RULE_05) A signal below its reference lowers the reference one count per downward period of rate times 200 ms.
// (RULE_06) With drift gain on, each downward step is the channel gain instead of one count.
// (RULE_07) While any channel is in detect, drifting is suspended on all channels.
// (RULE_08) After the last detect ends, drifting stays paused for the hold setting times 200 ms.
// (RULE_09) Drift gain enable resets to on and follows the bit written to the device control register.
// (RULE_10) Lumps drift like buttons; in low power only low-power channels are measured and drifted.
// (RULE_11) With lump member drifting on, members of a low-power lump are drifted in low-power mode too.
// (RULE_12) A drift step is assessed only once every ten measurement cycles.
// (RULE_13) Lump channels follow the buttons, the first lump at index 12 and the second at 13.
// (RULE_14) A delta held below the negative threshold for the configured count recalibrates the channel.
// (RULE_15) A channel enters detect when its delta rises above its threshold.
// (RULE_16) The delta is the signal minus the reference as a signed value.
`timescale 1ns/10ps
module tdr_drift_engine #(
	parameter int NUM_BTN = tdr_pkg::TDR_NUM_BTN,
	parameter int NUM_LUMP = tdr_pkg::TDR_NUM_LUMP,
	parameter int SIG_W = tdr_pkg::TDR_SIG_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Timebase
	input wire logic meas_tick,
	input wire logic tick_200ms,
	// Measurement data, one word per channel
	input wire logic [SIG_W-1:0] signal_in [NUM_BTN+NUM_LUMP],
	// Configuration
	input wire tdr_pkg::tdr_chan_cfg_t chan_cfg [NUM_BTN+NUM_LUMP],
	input wire tdr_pkg::tdr_drift_cfg_t drift_cfg,
	input wire tdr_pkg::tdr_conf_cfg_t conf_cfg,
	input wire tdr_pkg::tdr_reburst_t reburst_policy,
	input wire logic [NUM_BTN-1:0] lump_members [NUM_LUMP],
	// Device control write
	input wire logic device_control_wr,
	input wire logic drift_gain_wdata,
	input wire logic lump_member_drift_enable,
	input wire logic low_power_mode,
	input wire logic calibrate_req,
	// Status
	output logic [SIG_W-1:0] reference [NUM_BTN+NUM_LUMP],
	output logic [NUM_BTN+NUM_LUMP-1:0] detect,
	output logic [NUM_BTN+NUM_LUMP-1:0] reburst_req,
	output logic [NUM_BTN+NUM_LUMP-1:0] recal_done,
	output logic drift_gain_enable,
	output logic drift_paused
);
	import tdr_pkg::*;

	localparam int NUM_CH = NUM_BTN + NUM_LUMP;

	logic drift_gain_enable_q;
	logic [3:0] eval_div_q;
	logic [TDR_CFG_W-1:0] up_tmr_q;
	logic [TDR_CFG_W-1:0] down_tmr_q;
	logic [TDR_CFG_W-1:0] hold_q;
	logic up_due_q;
	logic down_due_q;
	logic cal_pend_q;
	logic [NUM_CH-1:0] det_q;
	logic [NUM_CH-1:0] pending;
	logic [NUM_CH-1:0] touching;
	logic [NUM_CH-1:0] active;
	logic [NUM_CH-1:0] recal;
	logic [NUM_CH-1:0] reburst_d;
	logic [NUM_CH-1:0] reburst_q;
	logic [NUM_CH-1:0] recal_q;
	logic [NUM_LUMP-1:0] lp_lump;
	logic [NUM_BTN-1:0] in_lp_lump;
	logic eval_now;
	logic any_det;
	logic pause;
	logic up_wrap;
	logic down_wrap;
	logic up_step;
	logic down_step;

	// Drift gain enable follows the control bit write
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			drift_gain_enable_q <= TDR_GAIN_RST; // RULE_09
		end else if (device_control_wr) begin
			drift_gain_enable_q <= drift_gain_wdata; // RULE_09
		end
	end

	// Assessment divider over measurement cycles
	assign eval_now = meas_tick && (eval_div_q == TDR_EVAL_LAST); // RULE_12
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			eval_div_q <= 4'h0;
		end else if (meas_tick) begin
			eval_div_q <= eval_now ? 4'h0 : eval_div_q + 4'h1; // RULE_12
		end
	end

	// Hold time after the last detect ends
	assign any_det = |det_q;
	assign pause = any_det || (hold_q != TDR_CNT_ZERO); // RULE_07 RULE_08
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hold_q <= TDR_CNT_ZERO;
		end else if (any_det) begin
			hold_q <= drift_cfg.drift_hold_time; // RULE_08
		end else if (tick_200ms && hold_q != TDR_CNT_ZERO) begin
			hold_q <= hold_q - TDR_CNT_ONE; // RULE_08
		end
	end

	// Drift period timers in 200 ms units; a zero rate disables that direction
	assign up_wrap = tick_200ms && (drift_cfg.upward_drift_rate != TDR_CNT_ZERO)
		&& (up_tmr_q + TDR_CNT_ONE >= drift_cfg.upward_drift_rate); // RULE_03
	assign down_wrap = tick_200ms && (drift_cfg.downward_drift_rate != TDR_CNT_ZERO)
		&& (down_tmr_q + TDR_CNT_ONE >= drift_cfg.downward_drift_rate); // RULE_05
	assign up_step = eval_now && up_due_q && !pause; // RULE_03 RULE_07 RULE_12
	assign down_step = eval_now && down_due_q && !pause; // RULE_05 RULE_07 RULE_12
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			up_tmr_q <= TDR_CNT_ZERO;
			down_tmr_q <= TDR_CNT_ZERO;
			up_due_q <= 1'b0;
			down_due_q <= 1'b0;
		end else begin
			if (tick_200ms) begin
				up_tmr_q <= up_wrap ? TDR_CNT_ZERO : up_tmr_q + TDR_CNT_ONE;
				down_tmr_q <= down_wrap ? TDR_CNT_ZERO : down_tmr_q + TDR_CNT_ONE;
			end
			up_due_q <= up_wrap || (up_due_q && !up_step); // Set wins over consume
			down_due_q <= down_wrap || (down_due_q && !down_step);
		end
	end

	// Calibration keeps confirmation measurements pending until the next measurement tick
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cal_pend_q <= 1'b0;
		end else begin
			cal_pend_q <= calibrate_req || (cal_pend_q && !meas_tick); // RULE_01
		end
	end

	// Low-power lumps and their member buttons
	always_comb begin
		in_lp_lump = '0;
		for (int k = 0; k < NUM_LUMP; k++) begin
			lp_lump[k] = chan_cfg[NUM_BTN+k].enable && chan_cfg[NUM_BTN+k].low_power_select; // RULE_13
			if (lp_lump[k]) begin
				in_lp_lump = in_lp_lump | lump_members[k]; // RULE_11
			end
		end
	end

	// Channel activity: all enabled in active mode, low-power set or low-power lump members with member drifting otherwise
	for (genvar i = 0; i < NUM_CH; i++) begin : g_act
		if (i < NUM_BTN) begin : g_btn
			assign active[i] = chan_cfg[i].enable && (!low_power_mode || chan_cfg[i].low_power_select
				|| (lump_member_drift_enable && in_lp_lump[i])); // RULE_10 RULE_11
		end else begin : g_lump
			assign active[i] = chan_cfg[i].enable
				&& (!low_power_mode || chan_cfg[i].low_power_select); // RULE_10 RULE_13
		end
	end

	// Per-channel delta, detect confirmation, anti-touch and drift
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		logic signed [SIG_W:0] delta;
		logic signed [SIG_W:0] thr_s;
		logic signed [SIG_W:0] neg_s;
		logic [SIG_W-1:0] ref_q;
		logic [SIG_W-1:0] ref_d;
		logic [SIG_W-1:0] step;
		logic [SIG_W-1:0] gap_up;
		logic [SIG_W-1:0] gap_down;
		logic [TDR_CFG_W-1:0] conf_q;
		logic [TDR_CFG_W-1:0] neg_q;
		logic above;
		logic below;
		logic mismatch;
		logic conf_done;
		logic meas;
		logic det_r;

		assign delta = $signed({1'b0, signal_in[i]}) - $signed({1'b0, ref_q}); // RULE_16
		assign thr_s = $signed({1'b0, chan_cfg[i].threshold});
		assign neg_s = -$signed({1'b0, conf_cfg.negative_recal_threshold});
		assign above = delta > thr_s; // RULE_15
		assign below = delta < neg_s; // RULE_14
		assign meas = meas_tick && active[i];
		assign mismatch = above != det_q[i];
		assign touching[i] = above || det_q[i]; // RULE_02
		assign conf_done = conf_q >= conf_cfg.detect_confirm_count;
		assign recal[i] = meas && below && !det_q[i]
			&& (neg_q + TDR_CNT_ONE >= conf_cfg.negative_recal_count); // RULE_14
		assign pending[i] = active[i] && (mismatch || (below && !det_q[i]) || cal_pend_q); // RULE_01

		// Step size and distance left to the signal, clamped so the reference lands on it
		assign step = drift_gain_enable_q ? SIG_W'(chan_cfg[i].gain) : SIG_W'(TDR_STEP_ONE); // RULE_04 RULE_06
		assign gap_up = signal_in[i] - ref_q;
		assign gap_down = ref_q - signal_in[i];

		// Next reference value
		always_comb begin
			ref_d = ref_q;
			if ((calibrate_req && active[i]) || recal[i]) begin
				ref_d = signal_in[i]; // RULE_14
			end else if (active[i] && !det_q[i] && delta > 0 && up_step) begin
				ref_d = ref_q + ((step < gap_up) ? step : gap_up); // RULE_03 RULE_04
			end else if (active[i] && !det_q[i] && delta < 0 && down_step) begin
				ref_d = ref_q - ((step < gap_down) ? step : gap_down); // RULE_05 RULE_06
			end
		end

		// Reference and state registers
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				ref_q <= '0;
				det_r <= 1'b0;
				conf_q <= TDR_CNT_ZERO;
				neg_q <= TDR_CNT_ZERO;
			end else begin
				ref_q <= ref_d;
				if (calibrate_req || recal[i]) begin
					det_r <= 1'b0;
					conf_q <= TDR_CNT_ZERO;
				end else if (meas && mismatch) begin
					det_r <= conf_done ? above : det_r; // RULE_15
					conf_q <= conf_done ? TDR_CNT_ZERO : conf_q + TDR_CNT_ONE; // RULE_01
				end else if (meas) begin
					conf_q <= TDR_CNT_ZERO;
				end
				if (calibrate_req || recal[i] || (meas && !(below && !det_q[i]))) begin
					neg_q <= TDR_CNT_ZERO; // A lone spike restarts the count
				end else if (meas) begin
					neg_q <= neg_q + TDR_CNT_ONE; // RULE_14
				end
			end
		end

		assign reference[i] = ref_q;
		assign det_q[i] = det_r;
	end

	// Reburst selection by policy
	always_comb begin
		unique case (reburst_policy)
			TDR_RB_NONE: reburst_d = '0; // RULE_02
			TDR_RB_UNRESOLVED: reburst_d = pending & touching; // RULE_02
			TDR_RB_ALL: reburst_d = (|pending) ? active : '0; // RULE_02
			default: reburst_d = '0;
		endcase
	end

	// Registered status
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reburst_q <= '0;
			recal_q <= '0;
		end else begin
			reburst_q <= reburst_d; // RULE_01
			recal_q <= recal;
		end
	end

	assign detect = det_q;
	assign reburst_req = reburst_q;
	assign recal_done = recal_q;
	assign drift_gain_enable = drift_gain_enable_q;
	assign drift_paused = pause;
endmodule

// ==== design/tdr_pkg.sv ====
// Shared constants and carrier types for the touch reference drift engine
package tdr_pkg;
	localparam int TDR_NUM_BTN = 12; // Physical buttons
	localparam int TDR_NUM_LUMP = 4; // Virtual lump channels after the buttons
	localparam int TDR_NUM_CH = TDR_NUM_BTN + TDR_NUM_LUMP;
	localparam int TDR_LUMP0_IDX = 12; // First lump channel index
	localparam int TDR_LUMP1_IDX = 13; // Second lump channel index
	localparam int TDR_SIG_W = 16; // Signal and reference width
	localparam int TDR_GAIN_W = 4; // Per-channel drift gain width
	localparam int TDR_CFG_W = 8; // Rate, hold and count setting width
	localparam int TDR_TICK_MS = 200; // Timebase unit in ms for rates and hold
	localparam int TDR_EVAL_DIV = 10; // Measurements per drift assessment
	localparam logic [3:0] TDR_EVAL_LAST = 4'h9; // Last divider state before assessment
	localparam logic [TDR_CFG_W-1:0] TDR_CNT_ZERO = 8'h00;
	localparam logic [TDR_CFG_W-1:0] TDR_CNT_ONE = 8'h01;
	localparam logic [TDR_GAIN_W-1:0] TDR_STEP_ONE = 4'h1; // Step without gain
	localparam logic TDR_GAIN_RST = 1'b1; // Drift gain enabled after reset

	// Extra confirmation measurement policy
	typedef enum logic [1:0] {
		TDR_RB_NONE,
		TDR_RB_UNRESOLVED,
		TDR_RB_ALL
	} tdr_reburst_t;

	// Per-channel configuration
	typedef struct packed {
		logic enable;
		logic low_power_select;
		logic [TDR_GAIN_W-1:0] gain;
		logic [TDR_SIG_W-1:0] threshold;
	} tdr_chan_cfg_t;

	// Global drift timing configuration, all in 200 ms units
	typedef struct packed {
		logic [TDR_CFG_W-1:0] upward_drift_rate;
		logic [TDR_CFG_W-1:0] downward_drift_rate;
		logic [TDR_CFG_W-1:0] drift_hold_time;
	} tdr_drift_cfg_t;

	// Anti-touch and detect confirmation configuration
	typedef struct packed {
		logic [TDR_SIG_W-1:0] negative_recal_threshold;
		logic [TDR_CFG_W-1:0] negative_recal_count;
		logic [TDR_CFG_W-1:0] detect_confirm_count;
	} tdr_conf_cfg_t;
endpackage

// ==== verification/tdr_drift_engine_bench.sv ====
// Directed bench for the drift engine
`timescale 1ns/10ps
module tdr_drift_engine_bench;
	import tdr_pkg::*;
	logic mclk, nrst, meas_tick, tick_200ms, device_control_wr, drift_gain_wdata, calibrate_req;
	logic lump_member_drift_enable, low_power_mode, drift_gain_enable, drift_paused;
	logic [15:0] signal_in [16];
	logic [15:0] reference [16];
	logic [15:0] detect, reburst_req, recal_done;
	tdr_chan_cfg_t chan_cfg [16];
	tdr_drift_cfg_t drift_cfg;
	tdr_conf_cfg_t conf_cfg;
	tdr_reburst_t reburst_policy;
	logic [11:0] lump_members [4];
	int bad_count = 0;
	int checked = 0;
	int cnt = 0;
	// Engine under test
	tdr_drift_engine DUT (.mclk, .nrst, .meas_tick, .tick_200ms, .signal_in, .chan_cfg, .drift_cfg, .conf_cfg,
		.reburst_policy, .lump_members, .device_control_wr, .drift_gain_wdata, .lump_member_drift_enable,
		.low_power_mode, .calibrate_req, .reference, .detect, .reburst_req, .recal_done, .drift_gain_enable,
		.drift_paused);
	// Clock
	initial begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end
	// Compare tasks
	task chk_v(input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t value %h expected %h", $time, g, e);
		end
	endtask
	task chk_b(input logic g, e);
		chk_v({15'h0, g}, {15'h0, e});
	endtask
	task print_verdict;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Stimulus helpers
	task w;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task step(input logic m, t, c);
		@(posedge mclk);
		meas_tick <= m;
		tick_200ms <= t;
		calibrate_req <= c;
		@(posedge mclk);
		meas_tick <= 0;
		tick_200ms <= 0;
		calibrate_req <= 0;
		cnt += m;
	endtask
	task meas(input int n);
		repeat (n) step(1, 0, 0);
		w;
	endtask
	task tk(input int n);
		repeat (n) step(0, 1, 0);
		w;
	endtask
	task sig(input logic [15:0] v);
		@(posedge mclk);
		signal_in[0] <= v;
	endtask
	task wr(input logic v);
		@(posedge mclk);
		device_control_wr <= 1;
		drift_gain_wdata <= v;
		@(posedge mclk);
		device_control_wr <= 0;
		w;
		chk_b(drift_gain_enable, v);
	endtask
	// Nine ticks hold the reference, the tenth takes the step
	task assess(input logic [15:0] e0, e1);
		meas(9 - cnt % 10);
		chk_v(reference[0], e0);
		meas(1);
		chk_v(reference[0], e1);
	endtask
	// Watchdog
	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		print_verdict;
	end
	// Main sequence
	initial begin
		{nrst, meas_tick, tick_200ms, device_control_wr, drift_gain_wdata, calibrate_req} = '0;
		{lump_member_drift_enable, low_power_mode} = '0;
		signal_in = '{default: 16'h0000};
		chan_cfg = '{default: '0};
		chan_cfg[0] = {1'h1, 1'h0, 4'h2, 16'h0064};
		chan_cfg[5] = {1'h1, 1'h0, 4'h1, 16'h0064};
		chan_cfg[12] = {1'h1, 1'h1, 4'h1, 16'h0064};
		lump_members = '{12'h060, 12'h000, 12'h000, 12'h000};
		drift_cfg = {8'h01, 8'h02, 8'h03};
		conf_cfg = {16'h0100, 8'h03, 8'h00};
		reburst_policy = TDR_RB_NONE;
		signal_in[0] = 16'h03e8;
		signal_in[5] = 16'h012c;
		signal_in[12] = 16'h02bc;
		repeat (20) @(posedge mclk);
		nrst <= 1;
		w;
		chk_b(drift_gain_enable, 1'h1);
		step(0, 0, 1);
		w;
		chk_v(reference[0], 16'h03e8);
		// Up and down steps, with and without gain
		sig(16'h03ed);
		tk(1);
		assess(16'h03e8, 16'h03ea);
		wr(0);
		tk(1);
		assess(16'h03ea, 16'h03eb);
		wr(1);
		sig(16'h03de);
		tk(2);
		assess(16'h03eb, 16'h03e9);
		wr(0);
		tk(2);
		assess(16'h03e9, 16'h03e8);
		wr(1);
		// Detect freezes drift, hold extends the pause
		sig(16'h04b0);
		meas(1);
		chk_v(detect, 16'h0001);
		tk(1);
		assess(16'h03e8, 16'h03e8);
		sig(16'h03ed);
		meas(1);
		chk_v(detect, 16'h0000);
		tk(2);
		chk_b(drift_paused, 1'h1);
		tk(1);
		chk_b(drift_paused, 1'h0);
		assess(16'h03e8, 16'h03ea);
		// Negative run with a break, then a full run
		@(posedge mclk);
		conf_cfg <= {16'h0014, 8'h03, 8'h00};
		sig(16'h03b6);
		meas(2);
		sig(16'h03ea);
		meas(1);
		sig(16'h03b6);
		meas(2);
		chk_v(reference[0], 16'h03ea);
		step(1, 0, 0);
		#1;
		chk_b(recal_done[0], 1'h1);
		w;
		chk_v(reference[0], 16'h03b6);
		// Low power: lump only, then lump members too
		@(posedge mclk);
		low_power_mode <= 1;
		signal_in[5] <= 16'h0190;
		signal_in[12] <= 16'h0320;
		step(0, 0, 1);
		w;
		chk_v(reference[5], 16'h012c);
		chk_v(reference[12], 16'h0320);
		chk_v(reference[0], 16'h03b6);
		@(posedge mclk);
		lump_member_drift_enable <= 1;
		step(0, 0, 1);
		w;
		chk_v(reference[5], 16'h0190);
		// Every policy while calibration is pending
		for (int p = 0; p < 3; p++) begin
			@(posedge mclk);
			reburst_policy <= tdr_reburst_t'(p);
			step(0, 0, 1);
			w;
			chk_v(reburst_req, (p == 2) ? 16'h1020 : 16'h0000);
		end
		// A touch on the lump makes it the only unresolved channel
		@(posedge mclk);
		reburst_policy <= TDR_RB_UNRESOLVED;
		signal_in[12] <= 16'h0420;
		w;
		chk_v(reburst_req, 16'h1000);
		print_verdict;
	end
endmodule

// ==== verification/tdr_drift_monitor.sv ====
// Port checks for the drift engine
`timescale 1ns/10ps
module tdr_drift_monitor #(
	parameter int NUM_BTN = tdr_pkg::TDR_NUM_BTN,
	parameter int NUM_LUMP = tdr_pkg::TDR_NUM_LUMP,
	parameter int SIG_W = tdr_pkg::TDR_SIG_W
) (
	// Clock, reset and strobes
	input wire logic mclk,
	input wire logic nrst,
	input wire logic meas_tick,
	input wire logic tick_200ms,
	input wire logic calibrate_req,
	input wire logic device_control_wr,
	input wire logic drift_gain_wdata,
	// Configuration
	input wire tdr_pkg::tdr_chan_cfg_t chan_cfg [NUM_BTN+NUM_LUMP],
	input wire tdr_pkg::tdr_reburst_t reburst_policy,
	// Status
	input wire logic [SIG_W-1:0] reference [NUM_BTN+NUM_LUMP],
	input wire logic [NUM_BTN+NUM_LUMP-1:0] detect,
	input wire logic [NUM_BTN+NUM_LUMP-1:0] reburst_req,
	input wire logic [NUM_BTN+NUM_LUMP-1:0] recal_done,
	input wire logic drift_gain_enable,
	input wire logic drift_paused
);
	import tdr_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Gain bit follows writes only
	chk_gain_write: assert property (
		device_control_wr |=> drift_gain_enable == $past(drift_gain_wdata)) else $error("gain write lost");
	chk_gain_hold: assert property (
		!device_control_wr |=> $stable(drift_gain_enable)) else $error("gain changed unwritten");
	// Pause and hold
	chk_pause_detect: assert property (
		|detect |-> drift_paused) else $error("detect without pause");
	chk_pause_end: assert property (
		$fell(drift_paused) && $past(detect) == '0 |-> $past(tick_200ms)) else $error("hold ended early");
	// Reference and detect move only on measurement or calibration
	chk_ref_tick: assert property (
		!meas_tick && !calibrate_req |=> $stable(reference[0])) else $error("reference moved idle");
	chk_detect_src: assert property (
		$changed(detect) |-> $past(meas_tick) || $past(calibrate_req)) else $error("detect moved idle");
	chk_recal_src: assert property (
		recal_done[0] |-> $past(meas_tick)) else $error("recal without tick");
	// Extra measurement policy
	chk_rb_none: assert property (
		reburst_policy == TDR_RB_NONE ##1 reburst_policy == TDR_RB_NONE |-> reburst_req == '0)
		else $error("reburst under none");
	chk_rb_active: assert property (
		reburst_req[0] |-> $past(chan_cfg[0].enable)) else $error("reburst on idle channel");
	cov_recal: cover property (recal_done[0]);
	cov_hold: cover property ($fell(drift_paused));
	cov_rb: cover property (reburst_req != '0);
endmodule
bind tdr_drift_engine tdr_drift_monitor #(.NUM_BTN(NUM_BTN), .NUM_LUMP(NUM_LUMP), .SIG_W(SIG_W)) u_mon (.mclk,
	.nrst, .meas_tick, .tick_200ms, .calibrate_req, .device_control_wr, .drift_gain_wdata, .chan_cfg,
	.reburst_policy, .reference, .detect, .reburst_req, .recal_done, .drift_gain_enable, .drift_paused);
